/* File: core/ind_addr.sv */
/*
  Indirect data addressing unit: pointer registers, indirect port
  redirection, direct extended access and the general purpose memory.
  Assumes the core presents one read or write per cycle on the request
  and takes read data one cycle later from the registered output.
*/
// Behaviour
// - Port accesses redirect to pointed memory location
// - Port zero reaches sector 0 only
// - Ports one, two use sector and low bytes
// - Indirect read of a port returns zero
// - Indirect write of a port does nothing
// - Five real pointer registers, read and write
// - Unassigned special locations read zero, stateless
// - Extended direct access reaches any sector
// - Full address is 10 bits, sector above
// - General storage 80H-FFH, specials 00H-7FH
module ind_addr
(
  // Clock and reset
  input  wire logic                                ref_clk_i,
  input  wire logic                                reset_n_i,
  // Core request
  input  wire ind_addr_pkg::mem_req_s              req_i,
  // Read answer
  output logic      [ind_addr_pkg::DATA_W-1:0]     rdata_o,
  output logic                                     rvalid_o
);

  // ****************************************************************
  // Pointer registers
  // ****************************************************************
  logic [7:0] pointer_zero_reg;
  logic [7:0] pointer_one_low_reg;
  logic [7:0] pointer_one_sector_reg;
  logic [7:0] pointer_two_low_reg;
  logic [7:0] pointer_two_sector_reg;

  // ****************************************************************
  // Effective address
  // ****************************************************************
  logic [ind_addr_pkg::ADDR_W-1:0] eff_addr;
  logic [7:0]                      eff_ofs;
  logic [7:0]                      req_ofs;
  logic                            indirect;
  logic                            to_port;
  logic                            gp_hit;
  logic                            wr_ok;
  logic [ind_addr_pkg::DATA_W-1:0] gp_rdata;
  logic [ind_addr_pkg::DATA_W-1:0] sfr_rdata;

  assign req_ofs = req_i.addr[7:0];

  always_comb
  begin
    indirect = 1'b1;
    eff_addr = req_i.addr;
    case (req_ofs)
      ind_addr_pkg::OFS_PORT_ZERO:
        eff_addr = {{ind_addr_pkg::SECTOR_W{1'b0}}, pointer_zero_reg};
      ind_addr_pkg::OFS_PORT_ONE:
        eff_addr = {pointer_one_sector_reg[ind_addr_pkg::SECTOR_W-1:0],
                    pointer_one_low_reg};
      ind_addr_pkg::OFS_PORT_TWO:
        eff_addr = {pointer_two_sector_reg[ind_addr_pkg::SECTOR_W-1:0],
                    pointer_two_low_reg};
      default:
        indirect = 1'b0;
    endcase
    if (req_ofs[ind_addr_pkg::GP_SEL_BIT])
    begin
      indirect = 1'b0;
      eff_addr = req_i.addr;
    end
  end

  assign eff_ofs = eff_addr[7:0];
  assign to_port = indirect &&
                   (eff_ofs == ind_addr_pkg::OFS_PORT_ZERO ||
                    eff_ofs == ind_addr_pkg::OFS_PORT_ONE  ||
                    eff_ofs == ind_addr_pkg::OFS_PORT_TWO);
  assign gp_hit  = eff_ofs[ind_addr_pkg::GP_SEL_BIT];
  assign wr_ok   = req_i.wr && !to_port;

  // ****************************************************************
  // Special register read mux
  // ****************************************************************
  always_comb
  begin
    case (eff_ofs)
      ind_addr_pkg::OFS_POINTER_ZERO:  sfr_rdata = pointer_zero_reg;
      ind_addr_pkg::OFS_POINTER_ONE_L: sfr_rdata = pointer_one_low_reg;
      ind_addr_pkg::OFS_POINTER_ONE_S: sfr_rdata = pointer_one_sector_reg;
      ind_addr_pkg::OFS_POINTER_TWO_L: sfr_rdata = pointer_two_low_reg;
      ind_addr_pkg::OFS_POINTER_TWO_S: sfr_rdata = pointer_two_sector_reg;
      default:
        sfr_rdata = ind_addr_pkg::READ_ZERO;
    endcase
  end

  // ****************************************************************
  // Pointer writes
  // ****************************************************************
  // Pointers sit below 80H; unassigned offsets get no enable, no state
  logic sfr_wr;
  logic wr_pointer_zero;
  logic wr_pointer_one_low;
  logic wr_pointer_one_sector;
  logic wr_pointer_two_low;
  logic wr_pointer_two_sector;

  assign sfr_wr = wr_ok && !gp_hit;
  assign wr_pointer_zero =
    sfr_wr && eff_ofs == ind_addr_pkg::OFS_POINTER_ZERO;
  assign wr_pointer_one_low =
    sfr_wr && eff_ofs == ind_addr_pkg::OFS_POINTER_ONE_L;
  assign wr_pointer_one_sector =
    sfr_wr && eff_ofs == ind_addr_pkg::OFS_POINTER_ONE_S;
  assign wr_pointer_two_low =
    sfr_wr && eff_ofs == ind_addr_pkg::OFS_POINTER_TWO_L;
  assign wr_pointer_two_sector =
    sfr_wr && eff_ofs == ind_addr_pkg::OFS_POINTER_TWO_S;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pointer_zero_reg <= ind_addr_pkg::POINTER_RESET;
    end
    else if (wr_pointer_zero)
    begin
      pointer_zero_reg <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pointer_one_low_reg <= ind_addr_pkg::POINTER_RESET;
    end
    else if (wr_pointer_one_low)
    begin
      pointer_one_low_reg <= req_i.wdata;
    end
  end

  // All eight bits are kept; only the low sector bits steer addressing
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pointer_one_sector_reg <= ind_addr_pkg::POINTER_RESET;
    end
    else if (wr_pointer_one_sector)
    begin
      pointer_one_sector_reg <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pointer_two_low_reg <= ind_addr_pkg::POINTER_RESET;
    end
    else if (wr_pointer_two_low)
    begin
      pointer_two_low_reg <= req_i.wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pointer_two_sector_reg <= ind_addr_pkg::POINTER_RESET;
    end
    else if (wr_pointer_two_sector)
    begin
      pointer_two_sector_reg <= req_i.wdata;
    end
  end

  // ****************************************************************
  // General purpose memory
  // ****************************************************************
  gp_ram #(
    .SECTOR_W (ind_addr_pkg::SECTOR_W),
    .IDX_W    (ind_addr_pkg::GP_IDX_W),
    .DATA_W   (ind_addr_pkg::DATA_W)
  ) u_gp_ram (
    .ref_clk_i (ref_clk_i),
    .we_i      (wr_ok && gp_hit),
    .waddr_i   ({eff_addr[9:8], eff_ofs[6:0]}),
    .wdata_i   (req_i.wdata),
    .raddr_i   ({eff_addr[9:8], eff_ofs[6:0]}),
    .rdata_o   (gp_rdata)
  );

  // ****************************************************************
  // Read answer
  // ****************************************************************
  // Answer strobe: one cycle after each read is taken
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= req_i.rd;
    end
  end

  // Read data holds until the next read is taken
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= ind_addr_pkg::READ_ZERO;
    end
    else if (req_i.rd)
    begin
      if (to_port)
        rdata_o <= ind_addr_pkg::READ_ZERO;
      else if (gp_hit)
        rdata_o <= gp_rdata;
      else
        rdata_o <= sfr_rdata;
    end
  end

endmodule // ind_addr

/* File: include/ind_addr_pkg.sv */
/*
  Package for the indirect data addressing unit: data memory geometry,
  special register offsets of the indirect ports and pointers, reset
  values and the core access request carrier.
  Assumes a byte-wide data memory of four sectors, 10-bit full address.
*/
package ind_addr_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned ADDR_W      = 10;
  localparam int unsigned SECTOR_W    = 2;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned SECTORS     = 4;
  localparam int unsigned GP_WORDS    = 128;
  localparam int unsigned GP_IDX_W    = 7;

  // ****************************************************************
  // Special register offsets (within a sector)
  // ****************************************************************
  localparam logic [7:0] OFS_PORT_ZERO      = 8'h00;
  localparam logic [7:0] OFS_POINTER_ZERO   = 8'h01;
  localparam logic [7:0] OFS_PORT_ONE       = 8'h02;
  localparam logic [7:0] OFS_POINTER_ONE_L  = 8'h03;
  localparam logic [7:0] OFS_POINTER_ONE_S  = 8'h04;
  localparam logic [7:0] OFS_PORT_TWO       = 8'h0C;
  localparam logic [7:0] OFS_POINTER_TWO_L  = 8'h0D;
  localparam logic [7:0] OFS_POINTER_TWO_S  = 8'h0E;
  localparam logic [7:0] OFS_GP_BASE        = 8'h80;
  localparam int unsigned GP_SEL_BIT        = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] POINTER_RESET      = 8'h00;
  localparam logic [7:0] READ_ZERO          = 8'h00;

  // ****************************************************************
  // Core access request
  // ****************************************************************
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_s;

endpackage

/* File: core/gp_ram.sv */
/*
  General purpose byte storage for all sectors, offsets 80H to FFH.
  Assumes a single synchronous write port and a combinational read.
*/
module gp_ram #(
  parameter int unsigned SECTOR_W = 2,
  parameter int unsigned IDX_W    = 7,
  parameter int unsigned DATA_W   = 8
) (
  // Clock
  input  wire logic                      ref_clk_i,
  // Write port
  input  wire logic                      we_i,
  input  wire logic [SECTOR_W+IDX_W-1:0] waddr_i,
  input  wire logic [DATA_W-1:0]         wdata_i,
  // Read port
  input  wire logic [SECTOR_W+IDX_W-1:0] raddr_i,
  output logic      [DATA_W-1:0]         rdata_o
);

  logic [DATA_W-1:0] mem [2**(SECTOR_W+IDX_W)];

  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];

endmodule // gp_ram

/* File: dv/ind_addr_sva.sv */
/* Port checker for ind_addr.
   Assumes one clock and at most one access a cycle. */
module ind_addr_sva (
  input wire logic                   ref_clk_i,
  input wire logic                   reset_n_i,
  input wire ind_addr_pkg::mem_req_s req_i,
  input wire logic [7:0]             rdata_o,
  input wire logic                   rvalid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic [7:0] ofs = req_i.addr[7:0];
  sequence s_rd_port0;
    req_i.rd && ofs == 8'h00;
  endsequence
  sequence s_rd_port1;
    req_i.rd && ofs == 8'h02;
  endsequence
  property p_zero;
    logic [7:0] p, d;
    (req_i.wr && ofs == 8'h01 && req_i.wdata[7], p = req_i.wdata) ##1
    (req_i.wr && ofs == 8'h00, d = req_i.wdata) ##1
    (req_i.rd && req_i.addr == {2'b00, p}) |=> rdata_o == d;
  endproperty
  property p_one;
    logic [9:0] a;
    logic [7:0] d;
    (req_i.wr && req_i.addr[7], a = req_i.addr, d = req_i.wdata) ##1
    (req_i.wr && ofs == 8'h03 && req_i.wdata == a[7:0]) ##1
    (req_i.wr && ofs == 8'h04 && req_i.wdata == {6'h00, a[9:8]}) ##1
    s_rd_port1 |=> rdata_o == d;
  endproperty
  property p_ptr;
    logic [7:0] d;
    (req_i.wr && ofs inside {8'h01, 8'h03, 8'h04, 8'h0D, 8'h0E},
     d = req_i.wdata) ##1 (req_i.rd && ofs == $past(ofs)) |=> rdata_o == d;
  endproperty
  a_read_answer: assert property (req_i.rd |=> rvalid_o)
    else $error("missing answer");
  a_no_stray: assert property (!req_i.rd |=> !rvalid_o)
    else $error("stray answer");
  a_data_holds: assert property (!req_i.rd |=> $stable(rdata_o))
    else $error("read data moved");
  a_unused_zero: assert property (req_i.rd && !req_i.addr[7] && !(ofs inside
    {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0C, 8'h0D, 8'h0E})
    |=> rdata_o == 8'h00) else $error("unused not zero");
  a_self_zero: assert property ((req_i.wr && ofs == 8'h01 &&
    req_i.wdata inside {8'h00, 8'h02, 8'h0C}) ##1 s_rd_port0
    |=> rdata_o == 8'h00) else $error("self read not zero");
  a_ind_zero: assert property (p_zero)
    else $error("port zero path");
  a_ind_one: assert property (p_one)
    else $error("port one path");
  a_ptr_back: assert property (p_ptr)
    else $error("pointer readback");
endmodule // ind_addr_sva

bind ind_addr ind_addr_sva chk (.ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i), .req_i(req_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o));

/* File: dv/core_model.sv */
/* Core-side access driver.
   Assumes the bench calls acc just after a rising edge. */
module core_model (
  input  wire logic              ref_clk_i,
  input  wire logic [7:0]        rdata_i,
  input  wire logic              rvalid_i,
  output ind_addr_pkg::mem_req_s req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  // One access, taken at the next edge; answer looked at after it
  task automatic acc(input logic r, input logic [9:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic v);
    req_o = '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge ref_clk_i);
    #1;
    q = rdata_i;
    v = (rvalid_i === r);
  endtask
  // Strobes drop low; address and data lines show the inverse of the last value
  task automatic idle();
    req_o = '{1'b0, 1'b0, ~req_o.addr, ~req_o.wdata};
  endtask
endmodule // core_model

/* File: dv/indirect_data_addressing_bench.sv */
/* Bench for ind_addr.
   Assumes core_model drives the request side. */
module indirect_data_addressing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   ref_clk_i = 1'b0;
  logic                   reset_n_i = 1'b0;
  ind_addr_pkg::mem_req_s req;
  logic [7:0]             rdata;
  logic                   rvalid;
  int                     error_cnt = 0;
  int                     tests_run = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  ind_addr dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid));
  core_model core (.ref_clk_i(ref_clk_i), .rdata_i(rdata),
    .rvalid_i(rvalid), .req_o(req));
  task automatic acc(input logic r, input logic [9:0] a,
    input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    core.acc(r, a, d, q, v);
    tests_run++;
    if (v !== 1'b1 || (r && q !== d))
      $display("wrong value at %0t: addr %h got %h", $time, a, q);
    if (v !== 1'b1 || (r && q !== d))
      error_cnt++;
  endtask
  task automatic t_pointers();
    logic [7:0] o [5] = '{8'h01, 8'h03, 8'h04, 8'h0D, 8'h0E};
    for (int i = 0; i < 5; i++) acc(0, {i[1:0], o[i]}, 8'h3C + 8'(i));
    for (int i = 0; i < 5; i++) acc(1, {2'(3 - i), o[i]}, 8'h3C + 8'(i));
    acc(0, 10'h10F, 8'hFF);
    acc(1, 10'h10F, 8'h00);
    acc(1, 10'h37F, 8'h00);
  endtask
  task automatic t_port_zero();
    acc(0, 10'h090, 8'hA5);
    acc(0, 10'h190, 8'h5A);
    acc(0, 10'h201, 8'h90);
    acc(1, 10'h000, 8'hA5);
    acc(0, 10'h001, 8'hA0);
    acc(0, 10'h100, 8'h66);
    acc(1, 10'h0A0, 8'h66);
    acc(1, 10'h190, 8'h5A);
  endtask
  task automatic t_port_one_two();
    acc(0, 10'h2C5, 8'h9E);
    acc(0, 10'h003, 8'hC5);
    acc(0, 10'h004, 8'h02);
    acc(1, 10'h002, 8'h9E);
    acc(0, 10'h002, 8'h4B);
    acc(1, 10'h2C5, 8'h4B);
    acc(0, 10'h281, 8'h77);
    acc(0, 10'h00D, 8'h81);
    acc(0, 10'h00E, 8'h02);
    acc(1, 10'h10C, 8'h77);
    acc(0, 10'h3F0, 8'hC3);
    acc(0, 10'h003, 8'hF0);
    acc(0, 10'h004, 8'h03);
    acc(1, 10'h002, 8'hC3);
  endtask
  task automatic t_self();
    acc(0, 10'h001, 8'h0C);
    acc(1, 10'h000, 8'h00);
    acc(0, 10'h003, 8'h02);
    acc(1, 10'h003, 8'h02);
    acc(0, 10'h002, 8'h99);
    acc(1, 10'h003, 8'h02);
    acc(1, 10'h002, 8'h00);
    acc(1, 10'h00C, 8'h77);
    core.idle();
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    #1;
    reset_n_i = 1'b1;
    t_pointers();
    t_port_zero();
    t_port_one_two();
    t_self();
    repeat (2) @(posedge ref_clk_i);
    finish_test();
  end
endmodule // indirect_data_addressing_bench
